// *** rtl/cse_top.sv ***
// Core register file, endianness, link reservation and condition state
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "cse_regs.svh"

module cse_top (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    // Avalon-MM register slave
    input  wire logic [`CSE_ADDR_W-1:0]    avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [`CSE_DATA_W-1:0]    avs_writedata,
    output logic      [`CSE_DATA_W-1:0]    avs_readdata,
    output logic                           avs_waitrequest,
    // Reset strap pin for memory endianness
    input  wire logic                      mem_endian_pin,
    // Pipeline read ports
    input  wire logic [`CSE_IDX_W-1:0]     rd_a_idx,
    input  wire logic                      rd_a_compact,
    input  wire logic [`CSE_IDX_W-1:0]     rd_b_idx,
    input  wire logic                      rd_b_compact,
    output logic      [`CSE_GPR_WIDTH-1:0] rd_a_data,
    output logic      [`CSE_GPR_WIDTH-1:0] rd_b_data,
    // Signed compare of the two read ports
    output logic                           cmp_lt,
    output logic                           cmp_gt,
    output logic                           cmp_le,
    output logic                           cmp_ge,
    // Pipeline write port
    input  wire logic                      wr_en,
    input  wire logic [`CSE_IDX_W-1:0]     wr_idx,
    input  wire logic                      wr_compact,
    input  wire logic [`CSE_GPR_WIDTH-1:0] wr_data,
    // Atomic sequence events
    input  wire logic                      ll_exec,
    input  wire logic                      sc_exec,
    input  wire logic                      eret_exec,
    input  wire logic                      store_conflict,
    output logic                           sc_success,
    output logic                           sc_done,
    output logic                           link_reservation_flag,
    // Endianness
    output logic                           mem_endian_flag,
    output logic                           endian_swap_signal,
    output logic                           loadstore_endian_flag,
    // Coprocessor condition
    input  wire logic                      coproc_condition_signal,
    output logic                           fp_condition_code
);

    // Width of the general registers, fixed for this build
    localparam int REG_W = `CSE_GPR_WIDTH;  // [RQ1]

    // Registered and next state
    cse_pkg::cse_state_t st_ff;
    cse_pkg::cse_state_t nxt_st;

    // Raw and translated indices, one lane per port (A, B, write)
    logic [2:0][`CSE_IDX_W-1:0] raw_idx;
    logic [2:0]                 raw_compact;
    logic [2:0][`CSE_IDX_W-1:0] full_idx;

    // Helper wires for the combinational process
    logic                       bus_req;     // Read or write pending
    logic                       bus_commit;  // Edge where wait is low
    logic [`CSE_SET_W-1:0]      set_now;     // Set used this cycle
    logic [REG_W-1:0]           a_val;       // Port A lookup
    logic [REG_W-1:0]           b_val;       // Port B lookup
    logic [`CSE_DATA_W-1:0]     ctrl_word;   // Control readback
    logic [`CSE_DATA_W-1:0]     stat_word;   // Status readback
    logic [`CSE_DATA_W-1:0]     win_word;    // Window readback

    // Gather the three register number inputs
    assign raw_idx     = {wr_idx, rd_b_idx, rd_a_idx};
    assign raw_compact = {wr_compact, rd_b_compact, rd_a_compact};

    // One translator per register port
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_xlat
            cse_xlat u_xlat (
                .idx_in  (raw_idx[g]),
                .compact (raw_compact[g]),
                .idx_out (full_idx[g])
            );
        end
    endgenerate

    // Shared lookups, kept out of the main process for readability
    assign bus_req    = avs_read | avs_write;
    assign bus_commit = bus_req & ~st_ff.wait_req;
    assign set_now    = st_ff.css;

    // Register zero never holds data, so lookups force it to zero
    assign a_val = (full_idx[0] == '0) ? '0
                 : st_ff.general_register[set_now][full_idx[0]];  // [RQ2] [RQ3]
    assign b_val = (full_idx[1] == '0) ? '0
                 : st_ff.general_register[set_now][full_idx[1]];  // [RQ2] [RQ3]

    // Control readback image
    always_comb begin
        ctrl_word = '0;
        ctrl_word[`CSE_CTRL_SWAP_BIT] = st_ff.ctrl_swap;
        ctrl_word[`CSE_CTRL_USER_BIT] = st_ff.ctrl_user;
        ctrl_word[`CSE_CTRL_CSS_LSB +: `CSE_SET_W] = st_ff.css;
    end

    // Status readback image: endianness, link, condition code and strap done bits
    always_comb begin
        stat_word = '0;
        stat_word[`CSE_STAT_MEM_BIT]  = st_ff.mem_endian;
        stat_word[`CSE_STAT_SWAP_BIT] = st_ff.swap;
        stat_word[`CSE_STAT_LS_BIT]   = st_ff.ls_endian;
        stat_word[`CSE_STAT_LINK_BIT] = st_ff.link;
        stat_word[`CSE_STAT_FCC_BIT]  = st_ff.fcc0;
        stat_word[`CSE_STAT_DONE_BIT] = st_ff.strap_done;
    end

    // Window readback: selected register of the current set
    always_comb begin
        if (st_ff.gpr_sel == '0) begin
            win_word = '0;  // [RQ2]
        end else begin
            win_word = st_ff.general_register[set_now][st_ff.gpr_sel];  // [RQ3]
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        nxt_st = st_ff;

        // Strap synchroniser; only stage 2 reads stage 1
        nxt_st.sync1 = mem_endian_pin;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.sync3 = st_ff.sync2;

        // Capture the strap once after release, when stages agree
        if (!st_ff.strap_done) begin
            if (st_ff.strap_cnt != `CSE_STRAP_SETTLE) begin
                nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
            end else if (st_ff.sync2 == st_ff.sync3) begin
                nxt_st.mem_endian = st_ff.sync3;  // [RQ4]
                nxt_st.strap_done = 1'b1;         // [RQ4]
            end
        end

        // Read ports and signed compares, one cycle latency
        nxt_st.rd_a = a_val;
        nxt_st.rd_b = b_val;
        nxt_st.lt = $signed(a_val) <  $signed(b_val);  // [RQ11]
        nxt_st.gt = $signed(a_val) >  $signed(b_val);  // [RQ11]
        nxt_st.le = $signed(a_val) <= $signed(b_val);  // [RQ11]
        nxt_st.ge = $signed(a_val) >= $signed(b_val);  // [RQ11]

        // Pipeline write; register zero silently drops it
        if (wr_en && (full_idx[2] != '0)) begin  // [RQ2]
            nxt_st.general_register[set_now][full_idx[2]] = wr_data;  // [RQ3]
        end

        // Bus handshake: wait drops for exactly one cycle per request
        nxt_st.wait_req = ~(bus_req & st_ff.wait_req);

        // Read data is latched while wait is dropping
        if (avs_read && st_ff.wait_req) begin
            if (avs_address == `CSE_OFS_CTRL) begin
                nxt_st.rdata = ctrl_word;
            end else if (avs_address == `CSE_OFS_STATUS) begin
                nxt_st.rdata = stat_word;
            end else if (avs_address == `CSE_OFS_GPR_SEL) begin
                nxt_st.rdata = {27'h0, st_ff.gpr_sel};
            end else if (avs_address == `CSE_OFS_GPR_DATA) begin
                nxt_st.rdata = win_word;
            end else begin
                nxt_st.rdata = '0;  // Unmapped reads as zero
            end
        end

        // Writes take effect at the edge where wait is sampled low
        if (avs_write && bus_commit) begin
            if (avs_address == `CSE_OFS_CTRL) begin
                nxt_st.ctrl_swap = avs_writedata[`CSE_CTRL_SWAP_BIT];
                nxt_st.ctrl_user = avs_writedata[`CSE_CTRL_USER_BIT];
                nxt_st.css =
                    avs_writedata[`CSE_CTRL_CSS_LSB +: `CSE_SET_W];
            end else if (avs_address == `CSE_OFS_GPR_SEL) begin
                nxt_st.gpr_sel = avs_writedata[`CSE_IDX_W-1:0];
            end else if (avs_address == `CSE_OFS_GPR_DATA) begin
                // Pipeline wins a same-register collision
                if ((st_ff.gpr_sel != '0) &&
                    !(wr_en && (full_idx[2] == st_ff.gpr_sel))) begin
                    nxt_st.general_register[set_now][st_ff.gpr_sel] =
                        avs_writedata[REG_W-1:0];  // [RQ2] [RQ3]
                end
            end
            // Status and unmapped writes are ignored
        end

        // Conditional store tests the reservation as it stands now
        nxt_st.sc_valid = sc_exec;
        nxt_st.sc_ok    = sc_exec & st_ff.link;  // [RQ7]

        // Anything that breaks atomicity drops the reservation
        if (eret_exec || store_conflict || sc_exec) begin
            nxt_st.link = 1'b0;  // [RQ8]
        end
        // A linked load in the same cycle wins over any clear
        if (ll_exec) begin
            nxt_st.link = 1'b1;  // [RQ7]
        end

        // Condition code zero follows the coprocessor condition
        nxt_st.fcc0 = coproc_condition_signal;  // [RQ9]

        // Swap only applies to user execution with the bit set
        nxt_st.swap = nxt_st.ctrl_swap & nxt_st.ctrl_user;  // [RQ5]
        nxt_st.ls_endian = nxt_st.mem_endian ^ nxt_st.swap;  // [RQ6]
    end

    // State register; reset gives every field a constant
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff          <= '0;           // [RQ12]
            st_ff.wait_req <= `CSE_RST_WAIT; // [RQ12]
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from state flops
    assign avs_readdata          = st_ff.rdata;
    assign avs_waitrequest       = st_ff.wait_req;
    assign rd_a_data             = st_ff.rd_a;
    assign rd_b_data             = st_ff.rd_b;
    assign cmp_lt                = st_ff.lt;
    assign cmp_gt                = st_ff.gt;
    assign cmp_le                = st_ff.le;
    assign cmp_ge                = st_ff.ge;
    assign sc_success            = st_ff.sc_ok;
    assign sc_done               = st_ff.sc_valid;
    assign link_reservation_flag = st_ff.link;
    assign mem_endian_flag       = st_ff.mem_endian;
    assign endian_swap_signal    = st_ff.swap;
    assign loadstore_endian_flag = st_ff.ls_endian;
    assign fp_condition_code     = st_ff.fcc0;

endmodule : cse_top

// *** rtl/cse_regs.svh ***
// Constants for the core state, endianness and link reservation block
//
// What this block does
// RQ1 - General registers have one fixed 32-bit width
// RQ2 - Register zero reads zero, ignores writes
// RQ3 - Register accesses go to current shadow set
// RQ4 - Memory endianness captured at reset, 1=big
// RQ5 - Swap signal only when swap bit and user
// RQ6 - Load/store endianness is memory flag XOR swap
// RQ7 - Linked load sets flag; conditional store tests it
// RQ8 - Flag cleared on conflict and exception return
// RQ9 - FP condition code zero mirrors coprocessor condition
// RQ10 - Compressed register numbers translated before access
// RQ11 - Ordering compares treat operands as signed
// RQ12 - All state returns to defined value on reset
`ifndef CSE_REGS_SVH
`define CSE_REGS_SVH

// Register file geometry
`define CSE_GPR_WIDTH       32
`define CSE_GPR_COUNT       32
`define CSE_SET_COUNT       4
`define CSE_SET_W           2
`define CSE_IDX_W           5
`define CSE_CIDX_W          3

// Bus geometry
`define CSE_ADDR_W          8
`define CSE_DATA_W          32

// Register byte offsets
`define CSE_OFS_CTRL        8'h00
`define CSE_OFS_STATUS      8'h04
`define CSE_OFS_GPR_SEL     8'h08
`define CSE_OFS_GPR_DATA    8'h0C

// Control register fields
`define CSE_CTRL_SWAP_BIT   0
`define CSE_CTRL_USER_BIT   1
`define CSE_CTRL_CSS_LSB    4

// Status register fields
`define CSE_STAT_MEM_BIT    0
`define CSE_STAT_SWAP_BIT   1
`define CSE_STAT_LS_BIT     2
`define CSE_STAT_LINK_BIT   3
`define CSE_STAT_FCC_BIT    4
`define CSE_STAT_DONE_BIT   5

// Reset values
`define CSE_RST_CTRL        32'h0000_0000
`define CSE_RST_WAIT        1'h1

// Strap settle count, cycles after reset release before capture
`define CSE_STRAP_SETTLE    2'h3

`endif

// *** rtl/cse_pkg.sv ***
// Types for the core state, endianness and link reservation block
`include "cse_regs.svh"

package cse_pkg;

    // One general register word
    typedef logic [`CSE_GPR_WIDTH-1:0] cse_word_t;

    // Whole register file: set, register, bit
    typedef logic [`CSE_SET_COUNT-1:0][`CSE_GPR_COUNT-1:0]
                  [`CSE_GPR_WIDTH-1:0] cse_file_t;

    // Complete state of the top module
    typedef struct packed {
        cse_file_t                general_register;        // All shadow sets
        logic                     ctrl_swap;  // User swap bit
        logic                     ctrl_user;  // Executing in user mode
        logic [`CSE_SET_W-1:0]    css;        // Current shadow set
        logic [`CSE_IDX_W-1:0]    gpr_sel;    // Bus window index
        logic                     wait_req;   // Bus waitrequest
        logic [`CSE_DATA_W-1:0]   rdata;      // Bus read data
        logic                     sync1;      // Strap sync stage 1
        logic                     sync2;      // Strap sync stage 2
        logic                     sync3;      // Strap sync stage 3
        logic [1:0]               strap_cnt;  // Settle counter
        logic                     strap_done; // Strap captured
        logic                     mem_endian; // Memory endianness
        logic                     swap;       // Endian swap signal
        logic                     ls_endian;  // Load/store endianness
        logic                     link;       // Link reservation
        logic                     sc_ok;      // Conditional store result
        logic                     sc_valid;   // Result strobe
        logic                     fcc0;       // FP condition code 0
        cse_word_t                rd_a;       // Read port A data
        cse_word_t                rd_b;       // Read port B data
        logic                     lt;         // A < B signed
        logic                     gt;         // A > B signed
        logic                     le;         // A <= B signed
        logic                     ge;         // A >= B signed
    } cse_state_t;

endpackage : cse_pkg

// *** rtl/cse_xlat.sv ***
// Compressed register number translation
`timescale 1ns/1ps
`include "cse_regs.svh"

module cse_xlat (
    // Register number in
    input  wire logic [`CSE_IDX_W-1:0] idx_in,
    input  wire logic                  compact,
    // Full register number out
    output logic      [`CSE_IDX_W-1:0] idx_out
);

    // Compressed field picks from 16,17,2..7; full field passes through
    always_comb begin
        idx_out = idx_in;
        if (compact) begin  // [RQ10]
            case (idx_in[`CSE_CIDX_W-1:0])
                3'h0:    idx_out = 5'h10;
                3'h1:    idx_out = 5'h11;
                default: idx_out = {2'h0, idx_in[`CSE_CIDX_W-1:0]};
            endcase
        end
    end

endmodule : cse_xlat

// *** rtl/cse_sizes_unused_placeholder.sv ***
// Intentionally empty
`timescale 1ns/1ps

// *** verif/cse_properties.sv ***
// Concurrent checks on the core state block ports
`timescale 1ns/1ps
`include "cse_regs.svh"

module cse_properties (
    // Clock and reset
    input wire logic                      core_clk,
    input wire logic                      rst_b,
    // Bus handshake
    input wire logic                      avs_read,
    input wire logic                      avs_write,
    input wire logic                      avs_waitrequest,
    // Read ports and compare
    input wire logic [`CSE_IDX_W-1:0]     rd_a_idx,
    input wire logic                      rd_a_compact,
    input wire logic [`CSE_GPR_WIDTH-1:0] rd_a_data,
    input wire logic [`CSE_GPR_WIDTH-1:0] rd_b_data,
    input wire logic                      cmp_lt,
    input wire logic                      cmp_gt,
    input wire logic                      cmp_le,
    input wire logic                      cmp_ge,
    // Atomic events
    input wire logic                      ll_exec,
    input wire logic                      sc_exec,
    input wire logic                      eret_exec,
    input wire logic                      store_conflict,
    input wire logic                      sc_success,
    input wire logic                      sc_done,
    input wire logic                      link_reservation_flag,
    // Endianness and condition
    input wire logic                      mem_endian_flag,
    input wire logic                      endian_swap_signal,
    input wire logic                      loadstore_endian_flag,
    input wire logic                      coproc_condition_signal,
    input wire logic                      fp_condition_code
);
    // One domain, so clock and disable are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // First edge after release still shows reset values
    property p_reset_state;
        !$past(rst_b) |-> !link_reservation_flag && !sc_done
            && avs_waitrequest;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("state not cleared by reset");

    // Exactly one wait cycle per request
    property p_bus_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("waitrequest did not drop");

    // Register zero reads zero in every set
    property p_reg_zero;
        rd_a_idx == 5'h00 && !rd_a_compact |=> rd_a_data == 32'h0000_0000;
    endproperty
    a_reg_zero: assert property (p_reg_zero)
        else $error("register zero not zero");

    // Compare flags follow signed read data
    property p_cmp_signed;
        $past(rst_b) |-> cmp_lt == ($signed(rd_a_data) < $signed(rd_b_data))
            && cmp_gt == ($signed(rd_a_data) > $signed(rd_b_data))
            && cmp_le == !cmp_gt && cmp_ge == !cmp_lt;
    endproperty
    a_cmp_signed: assert property (p_cmp_signed)
        else $error("compare flags wrong");

    // Allow one cycle of lag after either input moves
    property p_ls_endian;
        $stable(mem_endian_flag) && $stable(endian_swap_signal)
            |-> loadstore_endian_flag
                == (mem_endian_flag ^ endian_swap_signal);
    endproperty
    a_ls_endian: assert property (p_ls_endian)
        else $error("load store endianness wrong");

    // Condition code copies the input one cycle late
    property p_fcc;
        $past(rst_b) |-> fp_condition_code == $past(coproc_condition_signal);
    endproperty
    a_fcc: assert property (p_fcc)
        else $error("condition code mismatch");

    property p_ll_set;
        ll_exec |=> link_reservation_flag;
    endproperty
    a_ll_set: assert property (p_ll_set)
        else $error("linked load left flag clear");

    property p_eret_clr;
        eret_exec && !ll_exec |=> !link_reservation_flag;
    endproperty
    a_eret_clr: assert property (p_eret_clr)
        else $error("return left flag set");

    property p_conflict_clr;
        store_conflict && !ll_exec |=> !link_reservation_flag;
    endproperty
    a_conflict_clr: assert property (p_conflict_clr)
        else $error("conflict left flag set");

    // Result reflects the flag seen at the store
    property p_sc_result;
        sc_exec |=> sc_done && sc_success == $past(link_reservation_flag);
    endproperty
    a_sc_result: assert property (p_sc_result)
        else $error("conditional store result wrong");

    // Main scenarios reached
    c_sc_pass: cover property (sc_exec && link_reservation_flag);
    c_eret: cover property (eret_exec && link_reservation_flag);
    c_swap: cover property (endian_swap_signal);
endmodule : cse_properties

bind cse_top cse_properties i_props (.*);

// *** verif/cse_top_tb.sv ***
// Self-checking bench for the core state block
`timescale 1ns/1ps
`include "cse_regs.svh"

module cse_top_tb;
    localparam int LIMIT = 3000;           // Cycle ceiling, run needs ~210
    logic        core_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        mem_endian_pin = 1'h1;    // Strap big endian first
    logic [4:0]  rd_a_idx = 5'h00;
    logic [4:0]  rd_b_idx = 5'h00;
    logic        rd_a_compact = 1'h0;
    logic        rd_b_compact = 1'h0;
    logic [31:0] rd_a_data;
    logic [31:0] rd_b_data;
    logic        cmp_lt, cmp_gt, cmp_le, cmp_ge;
    logic        wr_en = 1'h0;
    logic [4:0]  wr_idx = 5'h00;
    logic        wr_compact = 1'h0;
    logic [31:0] wr_data = 32'h0;
    logic        ll_exec = 1'h0;
    logic        sc_exec = 1'h0;
    logic        eret_exec = 1'h0;
    logic        store_conflict = 1'h0;
    logic        sc_success, sc_done, link_reservation_flag;
    logic        mem_endian_flag, endian_swap_signal, loadstore_endian_flag;
    logic        coproc_condition_signal = 1'h0;
    logic        fp_condition_code;
    logic [31:0] rdv;                      // Last bus read data
    logic [31:0] va, vb;                   // Compare operands
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles = 0;

    // Every port shares its name with a bench signal
    cse_top i_dut (.*);

    // Free running clock, 5 ns period
    always #2.5 core_clk = ~core_clk;

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One bus cycle; request held until waitrequest seen low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge core_clk);
        while (avs_waitrequest !== 1'h0);
        rdv = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus

    // Index one edge, look just after the result edge
    task automatic pipe_rd(input logic [4:0] a, input logic ca,
                           input logic [4:0] b, input logic cb);
        @(posedge core_clk);
        rd_a_idx <= a;
        rd_a_compact <= ca;
        rd_b_idx <= b;
        rd_b_compact <= cb;
        @(posedge core_clk);
        #1;
    endtask : pipe_rd

    task automatic pipe_wr(input logic [4:0] i, input logic c,
                           input logic [31:0] d);
        @(posedge core_clk);
        wr_en <= 1'h1;
        wr_idx <= i;
        wr_compact <= c;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'h0;
    endtask : pipe_wr

    // Pulse {ll, sc, eret, conflict} for one cycle
    task automatic pulse(input logic [3:0] ev);
        @(posedge core_clk);
        {ll_exec, sc_exec, eret_exec, store_conflict} <= ev;
        @(posedge core_clk);
        {ll_exec, sc_exec, eret_exec, store_conflict} <= 4'h0;
        #1;
    endtask : pulse

    task automatic t_strap();
        repeat (8) @(posedge core_clk);
        bus(1'h0, `CSE_OFS_CTRL, 32'h0);
        check(rdv, `CSE_RST_CTRL);
        bus(1'h0, `CSE_OFS_STATUS, 32'h0);
        check(rdv & 32'h0000_003F, 32'h0000_0025);
    endtask : t_strap

    // Every swap bit and mode pairing
    task automatic t_endian();
        logic sw;
        for (int m = 0; m < 4; m++) begin
            bus(1'h1, `CSE_OFS_CTRL, 32'(m));
            sw = (m == 3);
            bus(1'h0, `CSE_OFS_STATUS, 32'h0);
            check(rdv[2:0], {!sw, sw, 1'h1});
            check(endian_swap_signal, sw);
        end
    endtask : t_endian

    task automatic t_shadow();
        for (int s = 0; s < 4; s++) begin
            bus(1'h1, `CSE_OFS_CTRL, 32'(s << 4));
            bus(1'h1, `CSE_OFS_GPR_SEL, 32'h5);
            bus(1'h1, `CSE_OFS_GPR_DATA, 32'hA0 + 32'(s));
            bus(1'h1, `CSE_OFS_GPR_SEL, 32'h0);
            bus(1'h1, `CSE_OFS_GPR_DATA, 32'hFFFF_FFFF);
            bus(1'h0, `CSE_OFS_GPR_DATA, 32'h0);
            check(rdv, 32'h0);
        end
        for (int s = 0; s < 4; s++) begin
            bus(1'h1, `CSE_OFS_CTRL, 32'(s << 4));
            pipe_wr(5'h00, 1'h0, 32'h1234_5678);
            pipe_rd(5'h05, 1'h0, 5'h00, 1'h0);
            check(rd_a_data, 32'hA0 + 32'(s));
            check(rd_b_data, 32'h0);
        end
    endtask : t_shadow

    task automatic t_compact();
        pipe_wr(5'h00, 1'h1, 32'h1111_1111);
        pipe_wr(5'h01, 1'h1, 32'h2222_2222);
        pipe_wr(5'h07, 1'h1, 32'h7777_7777);
        pipe_rd(5'h10, 1'h0, 5'h11, 1'h0);
        check(rd_a_data, 32'h1111_1111);
        check(rd_b_data, 32'h2222_2222);
        pipe_rd(5'h07, 1'h0, 5'h00, 1'h1);
        check(rd_a_data, 32'h7777_7777);
        check(rd_b_data, 32'h1111_1111);
    endtask : t_compact

    // Sign boundary pairs, equality last
    task automatic t_compare();
        logic [31:0] tab [8] = '{32'hFFFF_FFFF, 32'h1, 32'h1, 32'hFFFF_FFFF,
            32'h8000_0000, 32'h7FFF_FFFF, 32'h5, 32'h5};
        for (int k = 0; k < 8; k += 2) begin
            va = tab[k];
            vb = tab[k + 1];
            pipe_wr(5'h02, 1'h0, va);
            pipe_wr(5'h03, 1'h0, vb);
            pipe_rd(5'h02, 1'h0, 5'h03, 1'h0);
            check({cmp_lt, cmp_gt, cmp_le, cmp_ge},
                  {$signed(va) < $signed(vb), $signed(va) > $signed(vb),
                   $signed(va) <= $signed(vb),
                   $signed(va) >= $signed(vb)});
        end
    endtask : t_compare

    task automatic t_link();
        pulse(4'h8);
        check(link_reservation_flag, 1'h1);
        pulse(4'h4);
        check({sc_done, sc_success, link_reservation_flag}, 3'h6);
        pulse(4'h4);
        check({sc_done, sc_success}, 2'h2);
        pulse(4'h8);
        pulse(4'h2);
        check(link_reservation_flag, 1'h0);
        pulse(4'h8);
        pulse(4'h1);
        check(link_reservation_flag, 1'h0);
        pulse(4'hA);
        check(link_reservation_flag, 1'h1);
    endtask : t_link

    task automatic t_fcc();
        for (int v = 1; v >= 0; v--) begin
            @(posedge core_clk);
            coproc_condition_signal <= v[0];
            @(posedge core_clk);
            #1;
            check(fp_condition_code, v[0]);
        end
    endtask : t_fcc

    // Mid-run reset with little endian strap
    task automatic t_reset();
        @(posedge core_clk);
        mem_endian_pin <= 1'h0;
        rst_b <= 1'h0;
        #1;
        check(link_reservation_flag, 1'h0);
        repeat (3) @(posedge core_clk);
        rst_b <= 1'h1;
        repeat (8) @(posedge core_clk);
        check(mem_endian_flag, 1'h0);
        bus(1'h1, `CSE_OFS_CTRL, 32'h3);
        #1;
        check(loadstore_endian_flag, 1'h1);
    endtask : t_reset

    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'h1;
        t_strap();
        t_endian();
        t_shadow();
        t_compact();
        t_compare();
        t_link();
        t_fcc();
        t_reset();
        report_and_stop();
    end
endmodule : cse_top_tb
